// File: dv/sfh_host_model.sv
// sfh_host_model: host side that hands parsed request frames to the handler.
// assumes the handler takes a request on the edge where valid is high.
`timescale 1ns/10ps
module sfh_host_model (
	input  wire logic         clk_sys_i,
	output sfh_pkg::sfh_req_t req_o,
	output logic              req_valid_o
);
	// idle until the first request
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
	end

	// request driver
	// one-cycle request; fields turn to garbage once released
	task automatic send(input sfh_pkg::sfh_req_t r);
		@(posedge clk_sys_i);
		req_valid_o <= 1'b1;
		req_o <= r;
		@(posedge clk_sys_i);
		req_valid_o <= 1'b0;
		req_o <= ~r;
		#1;
	endtask : send
endmodule : sfh_host_model

// File: dv/sfh_socket_frame_handler_test.sv
// sfh_socket_frame_handler_test: scenario bench for the socket frame handler.
// assumes the host model drives requests; the network side is driven here.
`timescale 1ns/10ps
module sfh_socket_frame_handler_test;
	logic              clk_sys_i;
	logic              rst_i;
	logic              ce_i;
	logic              conn_done_i;
	logic [7:0]        conn_done_sock_i;
	logic              conn_ok_i;
	logic              rx_valid_i;
	sfh_pkg::sfh_rx_t  rx_i;
	logic [3:0]        sock_open_i;
	logic              req_valid;
	sfh_pkg::sfh_req_t req;
	logic              rsp_valid_o;
	sfh_pkg::sfh_rsp_t rsp_o;
	logic              rx_keep_o;
	logic [3:0]        close_o;
	int                failures;
	int                checked;

	sfh_host_model sfh_host_model_i (
		.clk_sys_i  (clk_sys_i),
		.req_o      (req),
		.req_valid_o(req_valid)
	);

	// clock enable driven by the bench so the freeze can be exercised
	sfh_socket_frame_handler #(.NSOCK(4)) sfh_socket_frame_handler_i (
		.clk_sys_i       (clk_sys_i),
		.rst_i           (rst_i),
		.ce_i            (ce_i),
		.req_valid_i     (req_valid),
		.req_i           (req),
		.conn_done_i     (conn_done_i),
		.conn_done_sock_i(conn_done_sock_i),
		.conn_ok_i       (conn_ok_i),
		.rx_valid_i      (rx_valid_i),
		.rx_i            (rx_i),
		.sock_open_i     (sock_open_i),
		.rsp_valid_o     (rsp_valid_o),
		.rsp_o           (rsp_o),
		.rx_keep_o       (rx_keep_o),
		.close_o         (close_o)
	);

	// 50 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// response word, looked at in the one cycle it stands
	task automatic rsp(input logic v, input logic [7:0] ft, id, sk, st);
		chk("rsp_valid", {7'h00, v}, {7'h00, rsp_valid_o});
		if (v) begin
			chk("frame_type", ft, rsp_o.frame_type);
			chk("frame_id", id, rsp_o.frame_id);
			chk("socket_id", sk, rsp_o.socket_id);
			chk("status", st, rsp_o.status);
		end
	endtask : rsp

	function automatic sfh_pkg::sfh_req_t mk(input logic [7:0] ft, id, sk);
		mk = '0;
		mk.frame_type = ft;
		mk.frame_id = id;
		mk.socket_id = sk;
		mk.addr_ok = 1'b1;
		mk.port = 16'h0050;
		mk.addr = 32'hC0A80001;
	endfunction : mk

	task automatic opt(input logic [7:0] sk, op, input logic pr, input logic [7:0] dv, st,
		input logic epr, input logic [7:0] ed);
		sfh_pkg::sfh_req_t r;
		r = mk(sfh_pkg::FT_OPT_REQ, 8'h11, sk);
		r.option_id = op;
		r.data_present = pr;
		r.data_byte = dv;
		sfh_host_model_i.send(r);
		rsp(1'b1, sfh_pkg::FT_OPT_RSP, 8'h11, sk, st);
		chk("option_id", op, rsp_o.option_id);
		chk("data_present", {7'h00, epr}, {7'h00, rsp_o.data_present});
		if (epr) chk("data_byte", ed, rsp_o.data_byte);
	endtask : opt

	task automatic conn(input logic [7:0] id, sk, at, input logic [15:0] pt, input logic ok,
		input logic ev, input logic [7:0] st);
		sfh_pkg::sfh_req_t r;
		r = mk(sfh_pkg::FT_CONN_REQ, id, sk);
		r.addr_type = at;
		r.port = pt;
		r.addr_ok = ok;
		sfh_host_model_i.send(r);
		rsp(ev, sfh_pkg::FT_CONN_RSP, id, sk, st);
	endtask : conn

	// network stack reports the end of a connect attempt; a stray report gives no frame
	task automatic done(input logic [7:0] sk, id, input logic ok, input logic ev);
		@(posedge clk_sys_i);
		conn_done_i <= 1'b1;
		conn_done_sock_i <= sk;
		conn_ok_i <= ok;
		@(posedge clk_sys_i);
		conn_done_i <= 1'b0;
		conn_done_sock_i <= ~sk;
		#1;
		rsp(ev, sfh_pkg::FT_STATUS, id, sk, ok ? 8'h00 : 8'h01);
	endtask : done

	task automatic rx(input logic [7:0] sk, input logic [31:0] a, input logic [15:0] p,
		input logic k);
		@(posedge clk_sys_i);
		rx_valid_i <= 1'b1;
		rx_i <= {sk, a, p};
		@(posedge clk_sys_i);
		rx_valid_i <= 1'b0;
		rx_i <= ~rx_i;
		#1;
		chk("rx_keep", {7'h00, k}, {7'h00, rx_keep_o});
	endtask : rx

	task automatic cls(input logic [7:0] id, sk, st, input logic ev, input logic [3:0] cl);
		sfh_host_model_i.send(mk(sfh_pkg::FT_CLOSE_REQ, id, sk));
		rsp(ev, sfh_pkg::FT_CLOSE_RSP, id, sk, st);
		chk("close", {4'h0, cl}, {4'h0, close_o});
	endtask : cls

	task automatic t_option;
		opt(8'h01, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 8'h00);
		opt(8'h01, 8'h00, 1'b1, 8'h02, 8'h00, 1'b0, 8'h00);
		opt(8'h01, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 8'h02);
		opt(8'h01, 8'h00, 1'b1, 8'h03, 8'h01, 1'b0, 8'h00);
		opt(8'h01, 8'h05, 1'b1, 8'h00, 8'h01, 1'b0, 8'h00);
		opt(8'h09, 8'h00, 1'b1, 8'h00, 8'h20, 1'b0, 8'h00);
		sock_open_i <= 4'b1101;
		opt(8'h01, 8'h00, 1'b1, 8'h00, 8'h20, 1'b0, 8'h00);
		sock_open_i <= 4'b1111;
		$display("test option done");
	endtask : t_option

	// a request offered while the enable is low is neither answered nor applied
	task automatic t_freeze;
		sfh_pkg::sfh_req_t r;
		r = mk(sfh_pkg::FT_OPT_REQ, 8'h11, 8'h01);
		r.data_present = 1'b1;
		r.data_byte = 8'h01;
		@(posedge clk_sys_i);
		ce_i <= 1'b0;
		sfh_host_model_i.send(r);
		chk("frozen_rsp_valid", 8'h00, {7'h00, rsp_valid_o});
		@(posedge clk_sys_i);
		ce_i <= 1'b1;
		opt(8'h01, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 8'h02);
		$display("test freeze done");
	endtask : t_freeze

	task automatic t_connect;
		conn(8'h07, 8'h02, 8'h00, 16'h0050, 1'b1, 1'b1, 8'h00);
		conn(8'h08, 8'h02, 8'h00, 16'h0050, 1'b1, 1'b1, 8'h03);
		done(8'h02, 8'h07, 1'b1, 1'b1);
		conn(8'h09, 8'h02, 8'h00, 16'h0050, 1'b1, 1'b1, 8'h04);
		conn(8'h0A, 8'h03, 8'h02, 16'h0050, 1'b1, 1'b1, 8'h01);
		conn(8'h0B, 8'h03, 8'h00, 16'h0050, 1'b0, 1'b1, 8'h02);
		conn(8'h0C, 8'h03, 8'h00, 16'h0000, 1'b1, 1'b1, 8'h02);
		conn(8'h0D, 8'h09, 8'h00, 16'h0050, 1'b1, 1'b1, 8'h20);
		conn(8'h00, 8'h03, 8'h01, 16'h0050, 1'b1, 1'b0, 8'h00);
		conn(8'h0E, 8'h03, 8'h00, 16'h0050, 1'b1, 1'b1, 8'h03);
		conn(8'h0F, 8'h00, 8'h00, 16'h0050, 1'b1, 1'b1, 8'h00);
		done(8'h00, 8'h0F, 1'b0, 1'b1);
		done(8'h00, 8'h0F, 1'b1, 1'b0);
		$display("test connect done");
	endtask : t_connect

	task automatic t_rx;
		rx(8'h02, 32'hC0A80001, 16'h0050, 1'b1);
		rx(8'h02, 32'hC0A80002, 16'h0050, 1'b0);
		rx(8'h02, 32'hC0A80001, 16'h0051, 1'b0);
		rx(8'h01, 32'hC0A80002, 16'h0051, 1'b1);
		rx(8'h09, 32'hC0A80001, 16'h0050, 1'b0);
		$display("test rx filter done");
	endtask : t_rx

	task automatic t_close;
		cls(8'h05, 8'h01, 8'h00, 1'b1, 4'b0010);
		cls(8'h06, 8'h07, 8'h20, 1'b1, 4'b0000);
		cls(8'h00, 8'h00, 8'h00, 1'b0, 4'b0001);
		cls(8'h07, 8'hFF, 8'h00, 1'b1, 4'b1111);
		conn(8'h10, 8'h02, 8'h00, 16'h0050, 1'b1, 1'b1, 8'h00);
		$display("test close done");
	endtask : t_close

	// mid-run reset brings socket 1's option value back to its default
	task automatic t_reset;
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		@(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1;
		chk("rst2_rsp_valid", 8'h00, {7'h00, rsp_valid_o});
		chk("rst2_close", 8'h00, {4'h0, close_o});
		opt(8'h01, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic wrap_up;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// hang guard: a run that overstays counts as a mismatch
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		failures++;
		wrap_up();
	end

	// reset, then the scenarios in order
	initial begin
		failures = 0;
		checked = 0;
		rst_i = 1'b1;
		ce_i = 1'b1;
		conn_done_i = 1'b0;
		conn_done_sock_i = 8'h00;
		conn_ok_i = 1'b0;
		rx_valid_i = 1'b0;
		rx_i = '0;
		sock_open_i = 4'b1111;
		repeat (5) @(posedge clk_sys_i);
		#1;
		chk("rst_rsp_valid", 8'h00, {7'h00, rsp_valid_o});
		@(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_option();
		t_freeze();
		t_connect();
		t_rx();
		t_close();
		t_reset();
		wrap_up();
	end
endmodule : sfh_socket_frame_handler_test

// File: verilog/sfh_pkg.sv
// sfh_pkg: frame codes, status codes and carrier types of the socket frame handler.
// assumes requests arrive already parsed into fields, one request per valid pulse.
package sfh_pkg;
	// frame types
	localparam logic [7:0] FT_OPT_REQ   = 8'h41;
	localparam logic [7:0] FT_CONN_REQ  = 8'h42;
	localparam logic [7:0] FT_CLOSE_REQ = 8'h43;
	localparam logic [7:0] FT_OPT_RSP   = 8'hC1;
	localparam logic [7:0] FT_CONN_RSP  = 8'hC2;
	localparam logic [7:0] FT_CLOSE_RSP = 8'hC3;
	localparam logic [7:0] FT_STATUS    = 8'hCF;
	// status codes
	localparam logic [7:0] ST_OK          = 8'h00;
	localparam logic [7:0] ST_BAD_PARAM   = 8'h01;
	localparam logic [7:0] ST_BAD_ADDR    = 8'h02;
	localparam logic [7:0] ST_NO_VALUE    = 8'h02;
	localparam logic [7:0] ST_IN_PROGRESS = 8'h03;
	localparam logic [7:0] ST_CONNECTED   = 8'h04;
	localparam logic [7:0] ST_UNKNOWN     = 8'h05;
	localparam logic [7:0] ST_BAD_SOCKET  = 8'h20;
	localparam logic [7:0] ST_CONN_FAIL   = 8'h01;
	// selectors and encodings
	localparam logic [7:0] SOCK_ALL       = 8'hFF;
	localparam logic [7:0] FRAME_ID_QUIET = 8'h00;
	localparam logic [7:0] ADDR_BINARY    = 8'h00;
	localparam logic [7:0] ADDR_TEXT      = 8'h01;
	localparam logic [7:0] OPT_TLS        = 8'h00;
	localparam logic [7:0] OPT_TLS_RESET  = 8'h00;
	localparam logic [7:0] OPT_TLS_MAX    = 8'h02;

	// parsed request from the host
	typedef struct packed {
		logic [7:0]  frame_type;
		logic [7:0]  frame_id;
		logic [7:0]  socket_id;
		logic [7:0]  option_id;
		logic        data_present;
		logic [7:0]  data_byte;
		logic [15:0] port;
		logic [7:0]  addr_type;
		logic [31:0] addr;
		logic        addr_ok;
	} sfh_req_t;

	// response frame header towards the host
	typedef struct packed {
		logic [7:0] frame_type;
		logic [7:0] frame_id;
		logic [7:0] socket_id;
		logic [7:0] option_id;
		logic [7:0] status;
		logic       data_present;
		logic [7:0] data_byte;
	} sfh_rsp_t;

	// received datagram header from the network side
	typedef struct packed {
		logic [7:0]  socket_id;
		logic [31:0] src_addr;
		logic [15:0] src_port;
	} sfh_rx_t;
endpackage : sfh_pkg

// File: verilog/sfh_socket_frame_handler.sv
// sfh_socket_frame_handler: answers option, connect and close requests with response frames.
// assumes a parsing stage upstream and a network stack that reports connect results.
//
// Summary of operation
// - option response 0xC1 with echoed fields
// - option status success, params, retrieve, socket; the code never sends a retrieve status, a query of option 0 on an open socket always answers with success
// - append option value only for queries
// - frame id zero suppresses connect/close response
// - address type 0 binary, 1 text
// - connected datagram socket drops foreign traffic
// - connect gives response then later status
// - connect response 0xC2 with echoed fields
// - connect status codes zero through four, 0x20
// - socket id 0xFF closes all sockets
// - empty option data means query
// - close response 0xC3, success or bad
`timescale 1ns/10ps
module sfh_socket_frame_handler #(
	parameter int NSOCK = 4
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic              req_valid_i,
	input  wire sfh_pkg::sfh_req_t req_i,
	input  wire logic              conn_done_i,
	input  wire logic [7:0]        conn_done_sock_i,
	input  wire logic              conn_ok_i,
	input  wire logic              rx_valid_i,
	input  wire sfh_pkg::sfh_rx_t  rx_i,
	input  wire logic [NSOCK-1:0]  sock_open_i,
	output logic                   rsp_valid_o,
	output sfh_pkg::sfh_rsp_t      rsp_o,
	output logic                   rx_keep_o,
	output logic [NSOCK-1:0]       close_o
);
	typedef enum logic [1:0] {SFH_IDLE, SFH_CONNECTING, SFH_CONNECTED} sfh_cstate_t;

	sfh_cstate_t        cst_q [NSOCK];
	sfh_cstate_t        cst_d [NSOCK];
	logic [31:0]        raddr_q [NSOCK];
	logic [31:0]        raddr_d [NSOCK];
	logic [15:0]        rport_q [NSOCK];
	logic [15:0]        rport_d [NSOCK];
	logic [7:0]         tls_q [NSOCK];
	logic [7:0]         tls_d [NSOCK];
	logic [7:0]         cfid_q [NSOCK];
	logic [7:0]         cfid_d [NSOCK];
	logic               rsp_valid_d;
	sfh_pkg::sfh_rsp_t  rsp_d;
	logic               rx_keep_d;
	logic [NSOCK-1:0]   close_d;
	logic               sock_ok;
	logic [7:0]         sidx;
	logic               rx_ok;
	logic [7:0]         ridx;

	// socket index checks; ids above the table are treated as unknown sockets
	always_comb begin
		sidx = req_i.socket_id;
		sock_ok = (sidx < 8'(NSOCK)) && sock_open_i[sidx[$clog2(NSOCK)-1:0]];
		ridx = rx_i.socket_id;
		rx_ok = ridx < 8'(NSOCK);
	end

	// request decode and per-socket state; one response per cycle, status frames lowest priority
	always_comb begin
		rsp_valid_d = 1'b0;
		rsp_d = '0;
		close_d = '0;
		rx_keep_d = 1'b0;
		for (int i = 0; i < NSOCK; i++) begin
			cst_d[i] = cst_q[i];
			raddr_d[i] = raddr_q[i];
			rport_d[i] = rport_q[i];
			tls_d[i] = tls_q[i];
			cfid_d[i] = cfid_q[i];
		end
		if (rx_valid_i && rx_ok) begin
			rx_keep_d = (cst_q[ridx[$clog2(NSOCK)-1:0]] != SFH_CONNECTED) ||
				((raddr_q[ridx[$clog2(NSOCK)-1:0]] == rx_i.src_addr) &&
				 (rport_q[ridx[$clog2(NSOCK)-1:0]] == rx_i.src_port));
		end
		rsp_d.frame_id = req_i.frame_id;
		rsp_d.socket_id = req_i.socket_id;
		if (req_valid_i) begin
			case (req_i.frame_type)
				sfh_pkg::FT_OPT_REQ: begin
					rsp_valid_d = 1'b1;
					rsp_d.frame_type = sfh_pkg::FT_OPT_RSP;
					rsp_d.option_id = req_i.option_id;
					if (!sock_ok) begin
						rsp_d.status = sfh_pkg::ST_BAD_SOCKET;
					end else if (req_i.option_id != sfh_pkg::OPT_TLS) begin
						rsp_d.status = sfh_pkg::ST_BAD_PARAM;
					end else if (!req_i.data_present) begin
						rsp_d.status = sfh_pkg::ST_OK;
						rsp_d.data_present = 1'b1;
						rsp_d.data_byte = tls_q[sidx[$clog2(NSOCK)-1:0]];
					end else if (req_i.data_byte > sfh_pkg::OPT_TLS_MAX) begin
						rsp_d.status = sfh_pkg::ST_BAD_PARAM;
					end else begin
						rsp_d.status = sfh_pkg::ST_OK;
						tls_d[sidx[$clog2(NSOCK)-1:0]] = req_i.data_byte;
					end
				end
				sfh_pkg::FT_CONN_REQ: begin
					rsp_d.frame_type = sfh_pkg::FT_CONN_RSP;
					rsp_valid_d = req_i.frame_id != sfh_pkg::FRAME_ID_QUIET;
					if (!sock_ok) begin
						rsp_d.status = sfh_pkg::ST_BAD_SOCKET;
					end else if (req_i.addr_type != sfh_pkg::ADDR_BINARY &&
						     req_i.addr_type != sfh_pkg::ADDR_TEXT) begin
						rsp_d.status = sfh_pkg::ST_BAD_PARAM;
					end else if (!req_i.addr_ok || req_i.port == 16'h0000) begin
						rsp_d.status = sfh_pkg::ST_BAD_ADDR;
					end else if (cst_q[sidx[$clog2(NSOCK)-1:0]] == SFH_CONNECTING) begin
						rsp_d.status = sfh_pkg::ST_IN_PROGRESS;
					end else if (cst_q[sidx[$clog2(NSOCK)-1:0]] == SFH_CONNECTED) begin
						rsp_d.status = sfh_pkg::ST_CONNECTED;
					end else begin
						rsp_d.status = sfh_pkg::ST_OK;
						cst_d[sidx[$clog2(NSOCK)-1:0]] = SFH_CONNECTING;
						raddr_d[sidx[$clog2(NSOCK)-1:0]] = req_i.addr;
						rport_d[sidx[$clog2(NSOCK)-1:0]] = req_i.port;
						cfid_d[sidx[$clog2(NSOCK)-1:0]] = req_i.frame_id;
					end
				end
				sfh_pkg::FT_CLOSE_REQ: begin
					rsp_d.frame_type = sfh_pkg::FT_CLOSE_RSP;
					rsp_valid_d = req_i.frame_id != sfh_pkg::FRAME_ID_QUIET;
					rsp_d.status = sfh_pkg::ST_OK;
					if (req_i.socket_id == sfh_pkg::SOCK_ALL) begin
						close_d = sock_open_i;
						for (int i = 0; i < NSOCK; i++) begin
							cst_d[i] = SFH_IDLE;
						end
					end else if (!sock_ok) begin
						rsp_d.status = sfh_pkg::ST_BAD_SOCKET;
					end else begin
						close_d[sidx[$clog2(NSOCK)-1:0]] = 1'b1;
						cst_d[sidx[$clog2(NSOCK)-1:0]] = SFH_IDLE;
					end
				end
				default: begin
					rsp_valid_d = 1'b0;
				end
			endcase
		end else if (conn_done_i && conn_done_sock_i < 8'(NSOCK)) begin
			if (cst_q[conn_done_sock_i[$clog2(NSOCK)-1:0]] == SFH_CONNECTING) begin
				rsp_valid_d = 1'b1;
				rsp_d.frame_type = sfh_pkg::FT_STATUS;
				rsp_d.frame_id = cfid_q[conn_done_sock_i[$clog2(NSOCK)-1:0]];
				rsp_d.socket_id = conn_done_sock_i;
				rsp_d.status = conn_ok_i ? sfh_pkg::ST_OK : sfh_pkg::ST_CONN_FAIL;
				cst_d[conn_done_sock_i[$clog2(NSOCK)-1:0]] =
					conn_ok_i ? SFH_CONNECTED : SFH_IDLE;
			end
		end
	end

	// registers; clock enable freezes everything, but reset is taken even while the enable is low
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_o <= '0;
			rx_keep_o <= 1'b0;
			close_o <= '0;
			for (int i = 0; i < NSOCK; i++) begin
				cst_q[i] <= SFH_IDLE;
				raddr_q[i] <= 32'h0000_0000;
				rport_q[i] <= 16'h0000;
				tls_q[i] <= sfh_pkg::OPT_TLS_RESET;
				cfid_q[i] <= 8'h00;
			end
		end else if (ce_i) begin
			rsp_valid_o <= rsp_valid_d;
			rsp_o <= rsp_d;
			rx_keep_o <= rx_keep_d;
			close_o <= close_d;
			for (int i = 0; i < NSOCK; i++) begin
				cst_q[i] <= cst_d[i];
				raddr_q[i] <= raddr_d[i];
				rport_q[i] <= rport_d[i];
				tls_q[i] <= tls_d[i];
				cfid_q[i] <= cfid_d[i];
			end
		end
	end

	AST_QUIET_CONN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && req_valid_i && req_i.frame_type == sfh_pkg::FT_CONN_REQ &&
		 req_i.frame_id == 8'h00) |=> !rsp_valid_o)
		else $error("connect with id zero answered");
	AST_OPT_TYPE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && req_valid_i && req_i.frame_type == sfh_pkg::FT_OPT_REQ) |=>
		(rsp_valid_o && rsp_o.frame_type == 8'hC1 && rsp_o.option_id == $past(req_i.option_id)))
		else $error("option response wrong");
	// data only on query
	// tied to the taken request so a frozen response word cannot misfire
	AST_OPT_DATA: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && req_valid_i && req_i.frame_type == sfh_pkg::FT_OPT_REQ) |=>
		(rsp_o.data_present ==
		 (!$past(req_i.data_present) && rsp_o.status == sfh_pkg::ST_OK)))
		else $error("option data on non query");
	AST_ECHO: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && req_valid_i) |=> (rsp_o.frame_id == $past(req_i.frame_id) &&
		rsp_o.socket_id == $past(req_i.socket_id)))
		else $error("identifier not echoed");
	AST_CLOSE_ST: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(rsp_valid_o && rsp_o.frame_type == 8'hC3) |-> (rsp_o.status inside {8'h00, 8'h20}))
		else $error("close status illegal");
	// close all pulses every open socket
	AST_CLOSE_ALL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && req_valid_i && req_i.frame_type == 8'h43 && req_i.socket_id == 8'hFF) |=>
		(close_o == $past(sock_open_i)))
		else $error("close all missed a socket");
	AST_CONN_TYPE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && req_valid_i && req_i.frame_type == 8'h42 && req_i.frame_id != 8'h00) |=>
		(rsp_valid_o && rsp_o.frame_type == 8'hC2))
		else $error("connect response missing");
	AST_ADDR_TYPE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(ce_i && req_valid_i && req_i.frame_type == 8'h42 && sock_ok && req_i.addr_type > 8'h01)
		|=> (rsp_o.status == 8'h01))
		else $error("bad address type not reported");
endmodule : sfh_socket_frame_handler
